// ---- mqf_pkg.sv ----
/*
 Shared constants, types and helpers for the multi-queue FIFO.
 Assumes a single device of the smallest block pool unless edited.
*/
`default_nettype none
package mqf_pkg;
    localparam int NUM_Q      = 32;
    localparam int QW         = 5;
    localparam int DW         = 36;
    localparam int BLK_WORDS  = 256;
    // Pool size of the density variant: 128, 256 or 512
    localparam int NUM_BLOCKS = 128;
    localparam int Q_BLOCKS   = NUM_BLOCKS / NUM_Q;
    localparam int Q_WORDS    = Q_BLOCKS * BLK_WORDS;
    localparam int PW         = $clog2(Q_WORDS) + 1;
    localparam int AW         = $clog2(NUM_BLOCKS * BLK_WORDS);
    localparam int SW_BITS    = 8;
    localparam int FIRST_BIT  = 34;
    localparam int LAST_BIT   = 35;

    typedef logic [PW-1:0] mqf_ptr_t;
    typedef logic [1:0]    mqf_width_t;
    typedef logic [1:0]    mqf_word_t;

    localparam mqf_ptr_t   Q_FULL      = mqf_ptr_t'(Q_WORDS);
    localparam mqf_ptr_t   DEF_OFFSET  = 11'h008;
    localparam mqf_width_t WIDTH_X9    = 2'h0;
    localparam mqf_width_t WIDTH_X18   = 2'h1;
    localparam logic [2:0] SETTLE_STD  = 3'h3;
    localparam logic [2:0] SETTLE_FALL_THROUGH_MODE = 3'h4;
    localparam logic [2:0] FALL_THROUGH_MODE_PIPE   = 3'h2;
    localparam logic [2:0] FALL_THROUGH_MODE_LOAD   = SETTLE_FALL_THROUGH_MODE - FALL_THROUGH_MODE_PIPE;

    typedef struct packed {
        mqf_ptr_t ptr;
        mqf_ptr_t last;
    } mqf_wprog_t;

    typedef enum logic [1:0] {
        RS_SETTLE = 2'b01,
        RS_RUN    = 2'b10
    } mqf_rstate_t;

    function automatic mqf_ptr_t bin2gray(input mqf_ptr_t b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    function automatic mqf_ptr_t gray2bin(input mqf_ptr_t g);
        mqf_ptr_t b;
        b[PW-1] = g[PW-1];
        for (int i = PW - 2; i >= 0; i--)
            b[i] = b[i+1] ^ g[i];
        return b;
    endfunction : gray2bin

    function automatic logic [DW-1:0] width_mask(input mqf_width_t w,
                                                 input logic [DW-1:0] d);
        logic [DW-1:0] r;
        r = d;
        if (w == WIDTH_X9)
            r = {27'h0, d[8:0]};
        else if (w == WIDTH_X18)
            r = {18'h0, d[17:0]};
        return r;
    endfunction : width_mask

    function automatic logic [SW_BITS-1:0] word_pick(input logic [NUM_Q-1:0] v,
                                                     input mqf_word_t w);
        return v[w * SW_BITS +: SW_BITS];
    endfunction : word_pick
endpackage : mqf_pkg
`default_nettype wire

// ---- mqf_sync.sv ----
/*
 Two-flop synchroniser for levels and gray-coded words.
 Assumes multi-bit inputs change at most one bit between samples.
*/
`default_nettype none
module mqf_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : mqf_sync
`default_nettype wire

// ---- mqf_ram.sv ----
/*
 Block pool storage: one write port, one registered read port.
 Assumes the two ports run on independent clocks.
*/
`default_nettype none
module mqf_ram
    import mqf_pkg::*;
(
    input  wire logic          wclk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic          rclk,
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output var  logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge wclk)
    begin
        if (we)
            mem[waddr] <= wdata;
    end

    always_ff @(posedge rclk)
    begin
        if (re)
            rdata <= mem[raddr];
    end
endmodule : mqf_ram
`default_nettype wire

// ---- mqf_core.sv ----
/*
 Multi-queue FIFO: write port and almost-full bus on mclk,
 read port and almost-empty bus on rd_clk.
 Assumes port inputs are synchronous to their own clock and that
 configuration inputs are static after reset.
*/
`default_nettype none
module mqf_core
    import mqf_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               rstn,
    input  wire logic               rd_clk,
    input  wire mqf_width_t         in_width,
    input  wire logic               pkt_mode,
    input  wire logic               flag_direct,
    input  wire logic               wr_cs,
    input  wire logic               wr_en,
    input  wire logic [QW-1:0]      wr_q,
    input  wire logic [DW-1:0]      wr_data,
    input  wire logic               af_prog_we,
    input  wire logic [QW-1:0]      af_prog_q,
    input  wire mqf_ptr_t           af_prog_val,
    input  wire mqf_word_t          af_word_sel,
    output var  logic               full_flag,
    output var  logic               almost_full_flag,
    output var  logic [SW_BITS-1:0] af_bus,
    output var  mqf_word_t          af_word,
    input  wire logic               fall_through_mode,
    input  wire mqf_width_t         out_width,
    input  wire logic               rd_cs,
    input  wire logic               rd_en,
    input  wire logic [QW-1:0]      rd_q,
    input  wire logic               ae_prog_we,
    input  wire logic [QW-1:0]      ae_prog_q,
    input  wire mqf_ptr_t           ae_prog_val,
    input  wire mqf_word_t          ae_word_sel,
    output var  logic [DW-1:0]      rd_data,
    output var  logic               rd_data_oe,
    output var  logic               empty_or_valid_flag,
    output var  logic               almost_empty_flag,
    output var  logic               packet_avail_flag,
    output var  logic [SW_BITS-1:0] ae_bus,
    output var  mqf_word_t          ae_word
);
    // Write domain state
    mqf_ptr_t   [NUM_Q-1:0] wptr, next_wptr, wlast, next_wlast;
    mqf_ptr_t   [NUM_Q-1:0] af_thr, next_af_thr, rgray_w, rptr_w, wlvl;
    mqf_wprog_t [NUM_Q-1:0] wgray, next_wgray;
    logic       [NUM_Q-1:0] af_all;
    logic                   w_accept, next_full, next_af;
    logic       [DW-1:0]    w_word;
    mqf_ptr_t               w_after;
    mqf_word_t              next_af_word;
    logic [SW_BITS-1:0]     next_af_bus;

    // Read domain state
    logic                   rd_rstn, pkt_r, direct_r;
    mqf_wprog_t [NUM_Q-1:0] wsync;
    mqf_ptr_t   [NUM_Q-1:0] rptr, next_rptr, rlast, next_rlast, rgray, next_rgray;
    mqf_ptr_t   [NUM_Q-1:0] ae_thr, next_ae_thr, wptr_r, rlvl;
    logic       [NUM_Q-1:0] rempty, ae_all, pkt_all;
    mqf_rstate_t            rstate, next_state;
    logic       [2:0]       cnt, next_cnt;
    logic       [QW-1:0]    cur_q, next_cur_q, pend_q;
    logic                   hold, next_hold, pend, issue, switching, run_ok;
    logic                   next_flag, next_pkt, cons_last;
    logic       [DW-1:0]    next_data, rdata;
    mqf_ptr_t               rollback;
    mqf_word_t              next_ae_word;
    logic [SW_BITS-1:0]     next_ae_bus;

    mqf_sync #(.W(1)) u_rst_sync (
        .clk  (rd_clk),
        .rstn (rstn),
        .d    (1'h1),
        .q    (rd_rstn)
    );

    mqf_sync #(.W(2)) u_cfg_sync (
        .clk  (rd_clk),
        .rstn (rd_rstn),
        .d    ({pkt_mode, flag_direct}),
        .q    ({pkt_r, direct_r})
    );

    mqf_sync #(.W($bits(wgray))) u_w2r (
        .clk  (rd_clk),
        .rstn (rd_rstn),
        .d    (wgray),
        .q    (wsync)
    );

    mqf_sync #(.W($bits(rgray))) u_r2w (
        .clk  (mclk),
        .rstn (rstn),
        .d    (rgray),
        .q    (rgray_w)
    );

    // queue base is a whole number of blocks
    // address spans the whole block pool
    mqf_ram u_ram (
        .wclk  (mclk),
        .we    (w_accept),
        .waddr ({wr_q, wptr[wr_q][PW-2:0]}),
        .wdata (w_word),
        .rclk  (rd_clk),
        .re    (issue),
        .raddr ({cur_q, rptr[cur_q][PW-2:0]}),
        .rdata (rdata)
    );

    for (genvar q = 0; q < NUM_Q; q++)
    begin : g_queue
        assign rptr_w[q]  = gray2bin(rgray_w[q]);
        assign wlvl[q]    = wptr[q] - rptr_w[q];
        assign af_all[q]  = wlvl[q] >= Q_FULL - af_thr[q];
        assign wptr_r[q]  = gray2bin(wsync[q].ptr);
        assign rlvl[q]    = wptr_r[q] - rptr[q];
        assign rempty[q]  = rlvl[q] == '0;
        assign ae_all[q]  = rlvl[q] <= ae_thr[q];
        // unread last markers mean a whole packet
        assign pkt_all[q] = gray2bin(wsync[q].last) != rlast[q];
    end

    always_comb
    begin
        next_wptr   = wptr;
        next_wlast  = wlast;
        next_af_thr = af_thr;
        // accept only while selected queue not full
        w_accept    = wr_cs && wr_en && (wlvl[wr_q] != Q_FULL);
        // input width applies to every queue
        w_word      = width_mask(in_width, wr_data);
        if (w_accept)
        begin
            next_wptr[wr_q] = wptr[wr_q] + 1'h1;
            // writer's last marker counted per queue
            if (pkt_mode && w_word[LAST_BIT])
                next_wlast[wr_q] = wlast[wr_q] + 1'h1;
        end
        if (af_prog_we)
            next_af_thr[af_prog_q] = af_prog_val;
        for (int q = 0; q < NUM_Q; q++)
        begin
            next_wgray[q].ptr  = bin2gray(next_wptr[q]);
            next_wgray[q].last = bin2gray(next_wlast[q]);
        end
        w_after   = wlvl[wr_q] + mqf_ptr_t'(w_accept);
        next_full = w_after == Q_FULL;
        next_af   = w_after >= Q_FULL - af_thr[wr_q];
        // polled word advances every write clock
        // two-bit index wraps back to word zero
        // direct word addressed from the write side
        next_af_word = flag_direct ? af_word_sel : af_word + 2'h1;
        // always four words, every bit maps to a queue
        next_af_bus  = word_pick(af_all, next_af_word);
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            wptr             <= '0;
            wlast            <= '0;
            wgray            <= '0;
            af_thr           <= {NUM_Q{DEF_OFFSET}};
            full_flag        <= 1'h0;
            almost_full_flag <= 1'h0;
            af_word          <= '0;
            af_bus           <= '0;
        end
        else
        begin
            wptr             <= next_wptr;
            wlast            <= next_wlast;
            wgray            <= next_wgray;
            af_thr           <= next_af_thr;
            full_flag        <= next_full;
            almost_full_flag <= next_af;
            af_word          <= next_af_word;
            af_bus           <= next_af_bus;
        end
    end

    always_comb
    begin
        next_rptr   = rptr;
        next_rlast  = rlast;
        next_ae_thr = ae_thr;
        next_cur_q  = cur_q;
        next_state  = rstate;
        next_cnt    = cnt;
        next_hold   = hold;
        next_data   = rd_data;
        switching   = rd_q != cur_q;
        run_ok      = (rstate == RS_RUN) && !switching && rd_cs;
        issue       = 1'h0;
        cons_last   = 1'h0;
        rollback    = mqf_ptr_t'({1'h0, hold} + {1'h0, pend});
        // no read is issued from an empty queue
        if (run_ok && !rempty[cur_q])
        begin
            // prefetch while output register is free
            // standard mode issues on every enable
            if (fall_through_mode)
                issue = !pend && (!hold || rd_en);
            else
                issue = rd_en;
        end
        if (issue)
            next_rptr[cur_q] = rptr[cur_q] + 1'h1;
        // output only changes when a word arrives
        if (pend && !(fall_through_mode && switching))
            next_data = width_mask(out_width, rdata);
        if (fall_through_mode)
        begin
            cons_last = run_ok && hold && rd_en && rd_data[LAST_BIT];
            if (switching)
                next_hold = 1'h0;
            else if (pend)
                next_hold = 1'h1;
            else if (run_ok && rd_en)
                next_hold = 1'h0;
        end
        else
            cons_last = pend && rdata[LAST_BIT];
        if (pkt_r && cons_last)
            next_rlast[pend_q] = rlast[pend_q] + 1'h1;
        if (ae_prog_we)
            next_ae_thr[ae_prog_q] = ae_prog_val;
        // settle before the flag describes a new queue
        case (rstate)
            RS_SETTLE:
            begin
                next_cnt = cnt - 3'h1;
                if (cnt == 3'h1)
                    next_state = RS_RUN;
            end
            RS_RUN:
                next_cnt = cnt;
            default:
                next_state = RS_SETTLE;
        endcase
        if (switching)
        begin
            // Prefetched words go back to their queue, not lost
            if (fall_through_mode)
                next_rptr[cur_q] = rptr[cur_q] - rollback;
            next_cur_q = rd_q;
            next_state = RS_SETTLE;
            next_cnt   = fall_through_mode ? FALL_THROUGH_MODE_LOAD : SETTLE_STD;
        end
        // writer must not reuse held slots
        for (int q = 0; q < NUM_Q; q++)
            if (fall_through_mode && q == int'(next_cur_q))
                next_rgray[q] = bin2gray(next_rptr[q] - mqf_ptr_t'(next_hold) - mqf_ptr_t'(issue));
            else
                next_rgray[q] = bin2gray(next_rptr[q]);
        // flag marks valid output word in fall-through, queue not empty in standard mode
        if (fall_through_mode)
            next_flag = (next_state == RS_RUN) && next_hold;
        else
            next_flag = (next_state == RS_RUN) && (rlvl[cur_q] != mqf_ptr_t'(issue));
        // packet flag beside the valid flag
        next_pkt = pkt_r && (next_state == RS_RUN) && pkt_all[cur_q];
    end

    always_comb
    begin
        // polled word advances every read clock
        // direct word addressed from the read side
        next_ae_word = direct_r ? ae_word_sel : ae_word + 2'h1;
        // same eight-queue words as the other bus
        next_ae_bus  = word_pick(pkt_r ? pkt_all : ae_all, next_ae_word);
    end

    always_ff @(posedge rd_clk or negedge rd_rstn)
    begin
        if (!rd_rstn)
        begin
            rptr                <= '0;
            rlast               <= '0;
            rgray               <= '0;
            ae_thr              <= {NUM_Q{DEF_OFFSET}};
            cur_q               <= '0;
            rstate              <= RS_SETTLE;
            cnt                 <= SETTLE_STD;
            hold                <= 1'h0;
            pend                <= 1'h0;
            pend_q              <= '0;
            rd_data             <= '0;
            rd_data_oe          <= 1'h0;
            empty_or_valid_flag <= 1'h0;
            almost_empty_flag   <= 1'h0;
            packet_avail_flag   <= 1'h0;
            ae_word             <= '0;
            ae_bus              <= '0;
        end
        else
        begin
            rptr                <= next_rptr;
            rlast               <= next_rlast;
            rgray               <= next_rgray;
            ae_thr              <= next_ae_thr;
            cur_q               <= next_cur_q;
            rstate              <= next_state;
            cnt                 <= next_cnt;
            hold                <= next_hold;
            pend                <= issue;
            pend_q              <= cur_q;
            rd_data             <= next_data;
            // shared output bus driven only when chip selected
            rd_data_oe          <= rd_cs;
            empty_or_valid_flag <= next_flag;
            almost_empty_flag   <= ae_all[rd_q];
            packet_avail_flag   <= next_pkt;
            ae_word             <= next_ae_word;
            ae_bus              <= next_ae_bus;
        end
    end
endmodule : mqf_core
`default_nettype wire

// ---- mqf_core_sva.sv ----
/*
 Port checker for mqf_core, both clock domains.
 Assumes configuration inputs only change while reset is low.
*/
`default_nettype none
module mqf_core_sva
    import mqf_pkg::*;
(
    input wire logic          mclk,
    input wire logic          rstn,
    input wire logic          rd_clk,
    input wire logic          pkt_mode,
    input wire logic          flag_direct,
    input wire mqf_word_t     af_word_sel,
    input wire logic          full_flag,
    input wire logic          almost_full_flag,
    input wire mqf_word_t     af_word,
    input wire logic          fall_through_mode,
    input wire logic          rd_cs,
    input wire logic          rd_en,
    input wire mqf_word_t     ae_word_sel,
    input wire logic [DW-1:0] rd_data,
    input wire logic          rd_data_oe,
    input wire logic          packet_avail_flag,
    input wire mqf_word_t     ae_word
);
    // Read side lags reset release; wait out the mode sync
    logic [3:0] rd_age;
    logic [3:0] next_rd_age;

    always_comb
        next_rd_age = (rd_age == 4'hF) ? rd_age : rd_age + 4'h1;

    always_ff @(posedge rd_clk or negedge rstn)
        if (!rstn)
            rd_age <= 4'h0;
        else
            rd_age <= next_rd_age;

    sequence s_idle4;
        (!rd_en) [*4];
    endsequence

    // write and read bus word steps
    // Release edge still resets the flops, so skip it
    a_af_poll_step: assert property (@(posedge mclk) disable iff (!rstn)
        rstn && !flag_direct ##1 !flag_direct |->
            af_word == mqf_word_t'($past(af_word) + 2'h1))
        else $error("af_word did not step");
    a_ae_poll_wrap: assert property (@(posedge rd_clk) disable iff (!rstn)
        rd_age > 4'h8 && !flag_direct && ae_word == 2'h3 |=> ae_word == 2'h0)
        else $error("ae_word did not wrap");
    a_af_direct: assert property (@(posedge mclk) disable iff (!rstn)
        rstn && flag_direct ##1 flag_direct |-> af_word == $past(af_word_sel))
        else $error("af_word not following select");
    a_ae_direct: assert property (@(posedge rd_clk) disable iff (!rstn)
        rd_age > 4'h8 && flag_direct |=> ae_word == $past(ae_word_sel))
        else $error("ae_word not following select");
    a_full_af: assert property (@(posedge mclk) disable iff (!rstn)
        full_flag |-> almost_full_flag)
        else $error("full without almost full");
    a_oe_follow: assert property (@(posedge rd_clk) disable iff (!rstn)
        rd_age > 4'h2 |-> rd_data_oe == $past(rd_cs))
        else $error("rd_data_oe not one edge after rd_cs");
    a_std_hold: assert property (@(posedge rd_clk) disable iff (!rstn)
        (rd_age > 4'h4 && !fall_through_mode) and s_idle4 |-> $stable(rd_data))
        else $error("rd_data moved without a read");
    // packet flag only in packet mode
    a_pkt_only: assert property (@(posedge rd_clk) disable iff (!rstn)
        !pkt_mode |-> !packet_avail_flag)
        else $error("packet flag outside packet mode");
endmodule : mqf_core_sva

bind mqf_core mqf_core_sva u_sva (.mclk, .rstn, .rd_clk, .pkt_mode, .flag_direct,
    .af_word_sel, .full_flag, .almost_full_flag, .af_word, .fall_through_mode, .rd_cs,
    .rd_en, .ae_word_sel, .rd_data, .rd_data_oe, .packet_avail_flag, .ae_word);
`default_nettype wire

// ---- mqf_host.sv ----
/*
 Reading host model: drives the read port on rd_clk.
 Assumes bench commands change just after rd_clk rising edges.
*/
`default_nettype none
module mqf_host
    import mqf_pkg::*;
(
    input  wire logic          rd_clk,
    input  wire logic          rstn,
    input  wire logic          cs,
    input  wire logic          go,
    input  wire logic [QW-1:0] sel,
    input  wire mqf_word_t     asel,
    output var  logic          rd_cs,
    output var  logic          rd_en,
    output var  logic [QW-1:0] rd_q,
    output var  mqf_word_t     ae_word_sel
);
    logic          next_rd_cs;
    logic          next_rd_en;
    logic [QW-1:0] next_rd_q;
    mqf_word_t     next_ae_word_sel;

    always_comb
    begin
        next_rd_cs       = cs;
        next_rd_en       = go;
        next_rd_q        = sel;
        next_ae_word_sel = asel;
    end

    always_ff @(posedge rd_clk or negedge rstn)
        if (!rstn)
            {rd_cs, rd_en, rd_q, ae_word_sel} <= '0;
        else
            {rd_cs, rd_en, rd_q, ae_word_sel} <=
                {next_rd_cs, next_rd_en, next_rd_q, next_ae_word_sel};
endmodule : mqf_host
`default_nettype wire

// ---- mqf_core_tb.sv ----
/*
 Self-checking bench for mqf_core: standard phase, then packet fall-through.
 Assumes mqf_host on the read port and the bound checker.
*/
`default_nettype none
module mqf_core_tb
    import mqf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic               mclk, rd_clk, rstn, pkt_mode, flag_direct, fall_through_mode;
    logic               wr_cs, wr_en, af_prog_we, ae_prog_we, rd_cs, rd_en, rd_data_oe;
    logic               full_flag, almost_full_flag, empty_or_valid_flag, cs, go;
    logic               almost_empty_flag, packet_avail_flag;
    logic [QW-1:0]      wr_q, af_prog_q, ae_prog_q, rd_q, sel;
    logic [DW-1:0]      wr_data, rd_data, seen, lastw;
    logic [SW_BITS-1:0] af_bus, ae_bus;
    mqf_width_t         in_width, out_width;
    mqf_ptr_t           af_prog_val, ae_prog_val;
    mqf_word_t          af_word_sel, ae_word_sel, af_word, ae_word, asel;
    logic [DW-1:0]      exp_q[$];
    int                 errors, total_checks;

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Offset so the two clocks never share edges
    initial
    begin
        rd_clk = 1'b0;
        #17;
        forever #62.5 rd_clk = ~rd_clk;
    end

    mqf_core dut (.mclk, .rstn, .rd_clk, .in_width, .pkt_mode, .flag_direct, .wr_cs,
        .wr_en, .wr_q, .wr_data, .af_prog_we, .af_prog_q, .af_prog_val, .af_word_sel,
        .full_flag, .almost_full_flag, .af_bus, .af_word, .fall_through_mode, .out_width,
        .rd_cs, .rd_en, .rd_q, .ae_prog_we, .ae_prog_q, .ae_prog_val, .ae_word_sel,
        .rd_data, .rd_data_oe, .empty_or_valid_flag, .almost_empty_flag,
        .packet_avail_flag, .ae_bus, .ae_word);
    mqf_host host (.rd_clk, .rstn, .cs, .go, .sel, .asel, .rd_cs, .rd_en, .rd_q,
        .ae_word_sel);

    task automatic chk(input string n, input logic [DW-1:0] got, input logic [DW-1:0] want);
        total_checks++;
        if (got !== want)
        begin
            errors++;
            $display("BAD %s exp %h got %h", n, want, got);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    // Each new output word must be the oldest one written
    always @(negedge rd_clk)
        if (!rstn)
            seen = '0;
        else if (rd_data !== seen)
        begin
            seen = rd_data;
            chk("rd_data", rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
        end

    task automatic wr(input logic [QW-1:0] q, input int n, input bit keep,
                      input logic [1:0] mk);
        logic [DW-1:0] d;
        for (int i = 0; i < n; i++)
        begin
            d = {(i == n - 1) & mk[1], (i == 0) & mk[0], 2'h0, $urandom()};
            @(posedge mclk);
            wr_cs   <= 1'b1;
            wr_en   <= 1'b1;
            wr_q    <= q;
            wr_data <= d;
            lastw = d;
            if (keep)
                exp_q.push_back(d);
        end
        @(posedge mclk);
        wr_en <= 1'b0;
        @(negedge mclk);
    endtask : wr

    task automatic rd_go(input int n);
        @(posedge rd_clk);
        go <= 1'b1;
        repeat (n) @(posedge rd_clk);
        go <= 1'b0;
        repeat (6) @(posedge rd_clk);
        @(negedge rd_clk);
    endtask : rd_go

    task automatic do_reset();
        rstn <= 1'b0;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask : do_reset

    initial
    begin
        #200000;
        errors++;
        summarize();
    end

    initial
    begin
        {rstn, pkt_mode, flag_direct, fall_through_mode, wr_cs, wr_en} = '0;
        {af_prog_we, ae_prog_we, cs, go, wr_q, af_prog_q, ae_prog_q, sel} = '0;
        {wr_data, af_prog_val, ae_prog_val, af_word_sel, asel} = '0;
        in_width = 2'h2;
        out_width = 2'h2;
        errors = 0;
        total_checks = 0;
        void'($urandom(32'hBBF3495B));
        do_reset();
        @(posedge mclk);
        af_prog_we  <= 1'b1;
        af_prog_q   <= 5'h05;
        af_prog_val <= 11'h010;
        @(posedge mclk);
        af_prog_we  <= 1'b0;
        @(negedge mclk);
        chk("full", DW'(full_flag), '0);
        wr(5'h03, 4, 1'b1, 2'h0);
        repeat (6) @(posedge rd_clk);
        cs  <= 1'b1;
        sel <= 5'h03;
        repeat (8) @(posedge rd_clk);
        rd_go(12);
        chk("pending", DW'(exp_q.size()), '0);
        $display("test std_read done");
        @(posedge rd_clk);
        sel <= 5'h07;
        repeat (8) @(posedge rd_clk);
        rd_go(4);
        chk("hold", rd_data, lastw);
        chk("empty", DW'(empty_or_valid_flag), '0);
        chk("aempty", DW'(almost_empty_flag), 36'h1);
        $display("test empty_switch done");
        // fill spans all blocks of the queue
        wr(5'h05, 1007, 1'b0, 2'h0);
        chk("afull", DW'(almost_full_flag), '0);
        wr(5'h05, 1, 1'b0, 2'h0);
        chk("afull", DW'(almost_full_flag), 36'h1);
        chk("full", DW'(full_flag), '0);
        wr(5'h05, 17, 1'b0, 2'h0);
        chk("full", DW'(full_flag), 36'h1);
        @(posedge mclk);
        wr_q <= 5'h06;
        @(posedge mclk);
        @(negedge mclk);
        chk("afull", DW'(almost_full_flag), '0);
        repeat (8)
        begin
            @(negedge mclk);
            if (af_word === 2'h0)
                break;
        end
        chk("af_bus5", DW'(af_bus[5]), 36'h1);
        chk("af_bus3", DW'(af_bus[3]), '0);
        @(posedge rd_clk);
        sel <= 5'h05;
        repeat (4) @(posedge rd_clk);
        @(negedge rd_clk);
        chk("aempty", DW'(almost_empty_flag), '0);
        @(posedge rd_clk);
        ae_prog_we  <= 1'b1;
        ae_prog_q   <= 5'h05;
        ae_prog_val <= 11'h400;
        @(posedge rd_clk);
        ae_prog_we  <= 1'b0;
        repeat (2) @(posedge rd_clk);
        @(negedge rd_clk);
        chk("aempty", DW'(almost_empty_flag), 36'h1);
        $display("test full_flags done");
        @(posedge rd_clk);
        {cs, sel} <= '0;
        @(posedge mclk);
        {pkt_mode, flag_direct, fall_through_mode} <= 3'h7;
        do_reset();
        wr(5'h09, 2, 1'b1, 2'h3);
        @(posedge mclk);
        af_word_sel <= 2'h1;
        repeat (6) @(posedge rd_clk);
        cs   <= 1'b1;
        sel  <= 5'h09;
        asel <= 2'h1;
        repeat (10) @(posedge rd_clk);
        @(negedge rd_clk);
        chk("af_word", DW'(af_word), 36'h1);
        chk("valid", DW'(empty_or_valid_flag), 36'h1);
        chk("pkt", DW'(packet_avail_flag), 36'h1);
        chk("ae_bus1", DW'(ae_bus[1]), 36'h1);
        rd_go(1);
        rd_go(1);
        chk("pkt", DW'(packet_avail_flag), '0);
        chk("valid", DW'(empty_or_valid_flag), '0);
        chk("pending", DW'(exp_q.size()), '0);
        $display("test packet_fall_through_mode done");
        summarize();
    end
endmodule : mqf_core_tb
`default_nettype wire
